// File: logic/rca_pkg.sv
// Shared constants for the calendar and match-register block
package rca_pkg;
	localparam int CLK_HZ      = 100_000_000;
	localparam int TICK_S      = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_S;
	localparam logic [6:0] DEV_ADDR = 7'h51;
	localparam logic [7:0] A_CTRL2  = 8'h01;
	localparam logic [7:0] A_SEC    = 8'h02;
	localparam logic [7:0] A_LAST   = 8'h0C;
	localparam int N_REGS = 11;
	localparam int N_TIME = 7;
	localparam int I_SEC  = 0;
	localparam int I_MIN  = 1;
	localparam int I_HR   = 2;
	localparam int I_DAY  = 3;
	localparam int I_WDAY = 4;
	localparam int I_MON  = 5;
	localparam int I_YR   = 6;
	localparam int I_AMIN = 7;
	localparam int I_AHR  = 8;
	localparam int I_ADAY = 9;
	localparam int I_AWD  = 10;
	localparam int B_DIS  = 7;
	localparam int B_CENT = 7;
	localparam int B_AF   = 3;
	localparam logic [2:0] BIT_LAST  = 3'h7;
	localparam logic [3:0] BCD_NINE  = 4'h9;
	localparam logic [7:0] CENT_MSK  = 8'h80;
	localparam logic [7:0] MON_FEB   = 8'h02;
	localparam logic [7:0] D28 = 8'h28;
	localparam logic [7:0] D29 = 8'h29;
	localparam logic [7:0] D30 = 8'h30;
	localparam logic [7:0] D31 = 8'h31;
	// Field mask, first and last value per time field, seconds..years
	localparam logic [7:0] MSK [N_TIME] =
		'{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h1F, 8'hFF};
	localparam logic [7:0] FST [N_TIME] =
		'{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
	localparam logic [7:0] LST [N_TIME] =
		'{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99};
	localparam logic [7:0] RST [N_REGS] = '{8'h80, 8'h80, 8'h00,
		8'h01, 8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80};
	typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_WR, ST_WACK,
		ST_RD, ST_RACK} rca_state_t;
endpackage

// File: logic/rca_calendar.sv
// Calendar counters, match registers and two-wire slave
// Contract
// - weekday 3-bit, Sunday 000 to Saturday 110
// - century bit held at month bit 7
// - century bit flips on year 99 to 00
// - month BCD, tens bit 4, units 3..0
// - year two BCD digits, bits 7..4, 3..0
// - no counting while bus access in progress
// - tick due during access applied afterwards
// - enabled match registers compared with current time
// - minute match: disable bit 7, BCD minute
// - hour match: disable bit 7, BCD hour
// - day match at 0Bh: disable bit 7, day
// - weekday match: disable bit 7, weekday 2..0
// - flag set when enabled fields newly match
// - flag stays set until host clears it
`timescale 1ns/10ps
module rca_calendar #(
	parameter int TICK_CYCLES = rca_pkg::TICK_CYCLES
) (
	input  wire logic core_clk,   // 100 MHz clock
	input  wire logic reset_n,    // Async reset
	input  wire logic scl_i,      // Serial clock pin
	input  wire logic sda_i,      // Serial data pin in
	output logic      sda_o,      // Serial data out, always low
	output logic      sda_oe,     // Pull data line low
	output logic      match_flag  // Alarm flag
);
	localparam int CW = $clog2(TICK_CYCLES);
	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	logic [7:0] regs_q [rca_pkg::N_REGS];
	logic [7:0] nxt [rca_pkg::N_TIME];
	logic [rca_pkg::N_TIME-1:0] en;
	logic [CW-1:0] div_q;
	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	logic scl_rise, scl_fall, start, stop;
	rca_pkg::rca_state_t st_q;
	logic [2:0] cnt_q;
	logic [7:0] sh_q, ptr_q, ridx, rd_byte;
	logic done_q, rw_q, busy_q, oe_q, sdo_q, af_q;
	logic tick, pend_q, inc, inc_q, pre_q, wr_en, in_map;
	logic c_sec, c_min, c_hr, c_day, c_mon, c_yr;
	logic [3:0] dis;
	logic [3:0] hit;
	logic match;

	assign sda_o      = sdo_q;
	assign sda_oe     = oe_q;
	assign match_flag = af_q;

	function automatic logic [7:0] bcd_next(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v == last)
			return first;
		else if (v[3:0] == rca_pkg::BCD_NINE)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return v + 8'h01;
	endfunction

	// Leap year when binary year divides by 4, BCD form
	function automatic logic [7:0] dim(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == rca_pkg::MON_FEB)
			return leap ? rca_pkg::D29 : rca_pkg::D28;
		else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09
			|| mon == 8'h11)
			return rca_pkg::D30;
		else
			return rca_pkg::D31;
	endfunction

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end
	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign start    = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign stop     = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

	// Time field carries, seconds upward
	always_comb begin
		c_sec = (regs_q[rca_pkg::I_SEC] & rca_pkg::MSK[0]) == rca_pkg::LST[0];
		c_min = c_sec && (regs_q[rca_pkg::I_MIN] & rca_pkg::MSK[1])
			== rca_pkg::LST[1];
		c_hr  = c_min && (regs_q[rca_pkg::I_HR] & rca_pkg::MSK[2])
			== rca_pkg::LST[2];
		c_day = c_hr && (regs_q[rca_pkg::I_DAY] & rca_pkg::MSK[3]) ==
			dim(regs_q[rca_pkg::I_MON] & rca_pkg::MSK[5],
				regs_q[rca_pkg::I_YR]);
		c_mon = c_day && (regs_q[rca_pkg::I_MON] & rca_pkg::MSK[5])
			== rca_pkg::LST[5];
		c_yr  = c_mon && regs_q[rca_pkg::I_YR] == rca_pkg::LST[6];
		en    = {c_mon, c_day, c_hr, c_hr, c_min, c_sec, 1'b1};
		for (int i = 0; i < rca_pkg::N_TIME; i++) begin
			nxt[i] = (regs_q[i] & ~rca_pkg::MSK[i])
				| (bcd_next(regs_q[i] & rca_pkg::MSK[i],
				i == rca_pkg::I_DAY ? (c_day ? regs_q[i] & rca_pkg::MSK[i]
				: 8'hFF) : rca_pkg::LST[i], rca_pkg::FST[i])
				& rca_pkg::MSK[i]);
		end
		if (c_yr)
			nxt[rca_pkg::I_MON] = nxt[rca_pkg::I_MON] ^ rca_pkg::CENT_MSK;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q  <= '0;
			pend_q <= 1'b0;
		end else begin
			div_q <= tick ? '0 : div_q + 1'b1;
			if (tick)
				pend_q <= 1'b1;
			else if (inc)
				pend_q <= 1'b0;
		end
	end
	assign tick = div_q == CW'(TICK_CYCLES - 1);
	assign inc  = pend_q & ~busy_q;

	assign ridx    = ptr_q - rca_pkg::A_SEC;
	assign in_map  = ptr_q >= rca_pkg::A_SEC && ptr_q <= rca_pkg::A_LAST;
	assign rd_byte = in_map ? regs_q[ridx[3:0]]
		: (ptr_q == rca_pkg::A_CTRL2 ? 8'(af_q) << rca_pkg::B_AF : 8'h00);
	assign wr_en   = scl_fall & ~start & ~stop & done_q & st_q == rca_pkg::ST_WR;

	// Bus writes only occur while busy, so they never meet an increment
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < rca_pkg::N_REGS; i++)
				regs_q[i] <= rca_pkg::RST[i];
		end else if (wr_en && in_map) begin
			regs_q[ridx[3:0]] <= sh_q;
		end else if (inc) begin
			for (int i = 0; i < rca_pkg::N_TIME; i++)
				if (en[i])
					regs_q[i] <= nxt[i];
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++)
			dis[i] = regs_q[rca_pkg::I_AMIN + i][rca_pkg::B_DIS];
		hit[0] = (regs_q[rca_pkg::I_AMIN] & rca_pkg::MSK[1])
			== (regs_q[rca_pkg::I_MIN] & rca_pkg::MSK[1]);
		hit[1] = (regs_q[rca_pkg::I_AHR] & rca_pkg::MSK[2])
			== (regs_q[rca_pkg::I_HR] & rca_pkg::MSK[2]);
		hit[2] = (regs_q[rca_pkg::I_ADAY] & rca_pkg::MSK[3])
			== (regs_q[rca_pkg::I_DAY] & rca_pkg::MSK[3]);
		hit[3] = (regs_q[rca_pkg::I_AWD] & rca_pkg::MSK[4])
			== (regs_q[rca_pkg::I_WDAY] & rca_pkg::MSK[4]);
		match = ~&dis && &(hit | dis);
	end

	// Flag only rises on an increment, never on a register write
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			inc_q <= 1'b0;
			pre_q <= 1'b0;
			af_q  <= 1'b0;
		end else begin
			inc_q <= inc;
			if (inc)
				pre_q <= match;
			if (inc_q && match && !pre_q)
				af_q <= 1'b1;
			else if (wr_en && ptr_q == rca_pkg::A_CTRL2 && !sh_q[rca_pkg::B_AF])
				af_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			sdo_q <= 1'b0;
		else
			sdo_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= rca_pkg::ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			ptr_q <= '0;
			done_q <= 1'b0;
			rw_q <= 1'b0;
			busy_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (start) begin
			st_q <= rca_pkg::ST_ADDR;
			cnt_q <= '0;
			done_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (stop) begin
			st_q <= rca_pkg::ST_IDLE;
			busy_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (scl_rise) begin
			case (st_q)
				rca_pkg::ST_ADDR, rca_pkg::ST_PTR, rca_pkg::ST_WR, rca_pkg::ST_RD: begin
					if (st_q != rca_pkg::ST_RD)
						sh_q <= {sh_q[6:0], sda_s2};
					cnt_q <= cnt_q + 3'h1;
					done_q <= cnt_q == rca_pkg::BIT_LAST;
				end
				rca_pkg::ST_RACK:
					if (sda_s2)
						st_q <= rca_pkg::ST_IDLE;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st_q)
				rca_pkg::ST_ADDR: if (done_q) begin
					done_q <= 1'b0;
					if (sh_q[7:1] == rca_pkg::DEV_ADDR) begin
						oe_q <= 1'b1;
						busy_q <= 1'b1;
						rw_q <= sh_q[0];
						st_q <= rca_pkg::ST_AACK;
					end else
						st_q <= rca_pkg::ST_IDLE;
				end
				rca_pkg::ST_AACK, rca_pkg::ST_RACK: if (rw_q) begin
					sh_q <= rd_byte;
					ptr_q <= ptr_q + 8'h01;
					oe_q <= ~rd_byte[7];
					st_q <= rca_pkg::ST_RD;
				end else begin
					oe_q <= 1'b0;
					st_q <= rca_pkg::ST_PTR;
				end
				rca_pkg::ST_PTR: if (done_q) begin
					done_q <= 1'b0;
					ptr_q <= sh_q;
					oe_q <= 1'b1;
					st_q <= rca_pkg::ST_WACK;
				end
				rca_pkg::ST_WR: if (done_q) begin
					done_q <= 1'b0;
					ptr_q <= ptr_q + 8'h01;
					oe_q <= 1'b1;
					st_q <= rca_pkg::ST_WACK;
				end
				rca_pkg::ST_WACK: begin
					oe_q <= 1'b0;
					st_q <= rca_pkg::ST_WR;
				end
				rca_pkg::ST_RD: if (done_q) begin
					done_q <= 1'b0;
					oe_q <= 1'b0;
					st_q <= rca_pkg::ST_RACK;
				end else begin
					sh_q <= {sh_q[6:0], 1'b0};
					oe_q <= ~sh_q[6];
				end
				default: ;
			endcase
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_WDAY_WRAP: assert property (inc && c_hr && regs_q[4][2:0] == 3'h6 |=> regs_q[4][2:0] == 3'h0) else $error("weekday wrap wrong");
	AST_CENT_FLIP: assert property (inc && c_yr |=> regs_q[5][7] != $past(regs_q[5][7])) else $error("century not flipped");
	AST_MON_WRAP: assert property (inc && c_mon |=> regs_q[5][4:0] == 5'h01) else $error("month wrap wrong");
	AST_YR_DIGIT: assert property (inc && c_mon && regs_q[6] == 8'h09 |=> regs_q[6] == 8'h10) else $error("year carry wrong");
	AST_FROZEN: assert property (busy_q && !wr_en |=> $stable(regs_q[0])) else $error("count during access");
	AST_DEFER: assert property (tick && busy_q |=> pend_q) else $error("tick lost");
	AST_DEFER_RUN: assert property ($fell(busy_q) && pend_q |-> inc) else $error("deferred tick not applied");
	AST_FLAG_SET: assert property (inc_q && match && !pre_q |=> af_q) else $error("flag not set");
	AST_FLAG_HOLD: assert property (af_q && !wr_en |=> af_q) else $error("flag dropped");
	AST_PTR_STEP: assert property (wr_en |=> ptr_q == $past(ptr_q) + 8'h01) else $error("pointer not advanced");
	AST_ALL_OFF: assert property (!dis[0] && hit[0] && &dis[3:1] |-> match) else $error("disabled field blocked match");
	COV_READ: cover property (st_q == rca_pkg::ST_RD ##1 st_q == rca_pkg::ST_RACK);
	COV_DEFER: cover property (tick && busy_q);
	COV_ALARM: cover property ($rose(af_q));
endmodule // rca_calendar

// File: sim/rca_host.sv
// Two-wire bus host model facing the calendar slave
`timescale 1ns/10ps
module rca_host (
	input  wire logic core_clk, // Bench clock
	input  wire logic sda_w,    // Resolved data line
	output logic      scl,      // Serial clock, still between frames
	output logic      sda_low   // High pulls the data line low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Eight clocks per phase, twice the slave's minimum
	task automatic hp();
		repeat (8) @(negedge core_clk);
	endtask
	// Also serves as repeated start
	task automatic start();
		sda_low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b1;
		hp();
		scl = 1'b0;
		hp();
	endtask
	task automatic stop();
		sda_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b0;
		hp();
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		hp();
		scl = 1'b1;
		hp();
		r = sda_w;
		scl = 1'b0;
		hp();
	endtask
	// Byte out or in, then ninth bit: nack=1 releases the line
	task automatic xfer(input logic [7:0] d, input logic nack,
		output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(nack, a);
		ack = ~a;
	endtask
endmodule // rca_host

// File: sim/rca_calendar_test.sv
// Register-level test of the calendar block over the two-wire bus
`timescale 1ns/10ps
module rca_calendar_test;
	localparam int TK = 5000;
	logic       core_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       scl, sda_low, sda_o, sda_oe, match_flag, ack;
	logic [7:0] rx, s0;
	logic [7:0] q [$];
	int         error_cnt = 0;
	int         checked = 0;
	wire        sda_w = ~(sda_oe | sda_low);
	always #5 core_clk = ~core_clk;
	rca_calendar #(.TICK_CYCLES(TK)) dut (.core_clk(core_clk),
		.reset_n(reset_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .match_flag(match_flag));
	rca_host host (.core_clk(core_clk), .sda_w(sda_w), .scl(scl),
		.sda_low(sda_low));
	task automatic final_report();
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %0t byte %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %0t bit %b expected %b", $time, g, e);
		end
	endtask
	task automatic cmpq(input logic [7:0] e [$], input int from);
		for (int i = from; i < e.size(); i++)
			chk8(q[i], e[i]);
	endtask
	task automatic addr(input logic [7:0] a);
		host.start();
		host.xfer(a, 1'b1, rx, ack);
		chk1(ack, 1'b1);
		chk1(sda_o, 1'b0);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d [$]);
		addr(8'hA2);
		host.xfer(p, 1'b1, rx, ack);
		foreach (d[i])
			host.xfer(d[i], 1'b1, rx, ack);
		host.stop();
	endtask
	// Leaves the bus held; caller issues stop or repeated start
	task automatic rd(input logic [7:0] p, input int n);
		addr(8'hA2);
		host.xfer(p, 1'b1, rx, ack);
		addr(8'hA3);
		q = {};
		for (int i = 0; i < n; i++) begin
			host.xfer(8'hFF, i == n - 1, rx, ack);
			q.push_back(rx);
		end
	endtask
	task automatic wait_flag();
		int i;
		for (i = 0; i < 3 * TK && match_flag !== 1'b1; i++)
			@(negedge core_clk);
		if (i == 3 * TK) begin
			error_cnt++;
			$display("mismatch %0t flag never rose", $time);
			final_report();
		end
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk1(sda_oe, 1'b0);
		chk1(match_flag, 1'b0);
		// Reset image, burst order, unmapped tail reads zero
		rd(8'h02, 12);
		host.stop();
		cmpq('{8'h80, 8'h80, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h80,
			8'h80, 8'h80, 8'h80, 8'h00}, 0);
		host.start();
		host.xfer(8'hA4, 1'b1, rx, ack);
		chk1(ack, 1'b0);
		host.stop();
		// Last second of the century
		wr(8'h02, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
		repeat (TK + 100) @(negedge core_clk);
		rd(8'h02, 7);
		host.stop();
		cmpq('{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00}, 1);
		// Ticks held across a long access, one applied after stop
		rd(8'h02, 1);
		s0 = q[0];
		repeat (TK + TK / 2) @(negedge core_clk);
		rd(8'h02, 1);
		chk8(q[0], s0);
		host.stop();
		rd(8'h02, 1);
		host.stop();
		chk8(q[0], s0 + 8'h01);
		// Minute match one or two ticks away; disabled hour differs
		wr(8'h02, '{8'h58, 8'h00, 8'h05, 8'h15, 8'h03, 8'h06, 8'h24,
			8'h01, 8'h80, 8'h80, 8'h80});
		chk1(match_flag, 1'b0);
		wait_flag();
		rd(8'h01, 1);
		host.stop();
		chk8(q[0], 8'h08);
		wr(8'h01, '{8'h00});
		chk1(match_flag, 1'b0);
		repeat (TK + 100) @(negedge core_clk);
		chk1(match_flag, 1'b0);
		final_report();
	end
endmodule // rca_calendar_test
